// [sdrar_map.vh]
// Constants for the activate and read-burst logic of the graphics DRAM model.
// Assumes inclusion by bare name from the design files.
`ifndef SDRAR_MAP_VH
`define SDRAR_MAP_VH
// ----------------------------------------
// Command encodings {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------
`define SDRAR_CMD_ACT 4'h3
`define SDRAR_CMD_READ 4'h5
`define SDRAR_CMD_WRITE 4'h4
`define SDRAR_CMD_PRE 4'h2
// ----------------------------------------
// Address fields
// ----------------------------------------
`define SDRAR_AP_BIT 8
// ----------------------------------------
// Timing at a 25 ns clock; the NS values are in ns, the rest are cycles or counts
// ----------------------------------------
`define SDRAR_CLK_PERIOD_NS 25
`define SDRAR_RAS_MIN_NS 50
`define SDRAR_BURST_LEN 4
`define SDRAR_NIBBLE_CYCLES 2
`define SDRAR_CAS_LAT_DEFAULT 4'h5
`define SDRAR_ODT_HOLD 4'h2
`endif

// [sdrar_sync.v]
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes CLK is the block clock; stage one is read only by stage two.
`timescale 1ns/10ps
module sdrar_sync #(
    parameter W = 1
) (
    input wire CLK,
    input wire RST_N,
    input wire [W-1:0] D,
    output reg [W-1:0] Q
);
    reg [W-1:0] s1;
    reg [W-1:0] s2;
    reg [W-1:0] s3;
    genvar i;
    always @(posedge CLK) begin
        if (!RST_N) begin
            s1 <= {W{1'b0}};
            s2 <= {W{1'b0}};
            s3 <= {W{1'b0}};
        end else begin
            s1 <= D;
            s2 <= s1;
            s3 <= s2;
        end
    end
    generate
        for (i = 0; i < W; i = i + 1) begin : g_agree
            // A change counts only once stages two and three agree
            always @(posedge CLK) begin
                if (!RST_N) begin
                    Q[i] <= 1'b0;
                end else if (s2[i] == s3[i]) begin
                    Q[i] <= s3[i];
                end
            end
        end
    endgenerate
endmodule // sdrar_sync

// [sdrar_bank.v]
// Per-bank open-row tracker with row active timer and auto precharge.
// Assumes command strobes are single CLK pulses in the sampled domain.
`timescale 1ns/10ps
`include "sdrar_map.vh"
module sdrar_bank #(
    parameter ROW_W = 12,
    parameter RAS_CYC = 2
) (
    input wire CLK,
    input wire RST_N,
    input wire act,
    input wire pre,
    input wire ap_req,
    input wire burst_done,
    input wire [ROW_W-1:0] row_in,
    output reg open,
    output reg [ROW_W-1:0] row,
    output reg ap_pending
);
    reg [7:0] ras_cnt;
    wire ras_met = (ras_cnt == 8'h00);
    always @(posedge CLK) begin
        if (!RST_N) begin
            open <= 1'b0;
            row <= {ROW_W{1'b0}};
            ras_cnt <= 8'h00;
            ap_pending <= 1'b0;
        end else begin
            if (ras_cnt != 8'h00) begin
                ras_cnt <= ras_cnt - 8'h01;
            end
            if (act) begin
                open <= 1'b1;
                row <= row_in;
                ras_cnt <= RAS_CYC[7:0];
                ap_pending <= 1'b0;
            end else if (pre) begin
                open <= 1'b0;
                ap_pending <= 1'b0;
            end else begin
                if (ap_req) begin
                    ap_pending <= 1'b1;
                end
                // Close only after the burst and the active time both end
                if ((ap_pending || ap_req) && burst_done && ras_met) begin
                    open <= 1'b0;
                    ap_pending <= 1'b0;
                end
            end
        end
    end
endmodule // sdrar_bank

// [sdrar_core.v]
// Activate and read-burst behaviour of a x32 graphics DRAM, device side.
// Assumes the controller's CK is sampled by a faster CLK; the memory
// array is a small model and the column field selects within it.
`timescale 1ns/10ps
`include "sdrar_map.vh"
// Behaviour
// - Activate captures bank and row, opens it
// - Cross bank activates allowed, spaced by interval
// - Read captures column, bank, auto precharge
// - Auto precharge after burst and active time
// - First data after CAS latency, then edges
// - Data edge aligned to clock and strobe
// - Strobe driven high half cycle early
// - Postamble is half cycle of last element
// - Data lines float when burst ends
// - Reads nibble cycles apart join seamlessly
// - Read bursts never truncated
// - Termination off while reading
// - Four strobes, one per byte lane
// - Burst of four follows programmed order
// - Random reads at full speed, any bank
module sdrar_core #(
    parameter ROW_W = 12,
    parameter COL_W = 8,
    parameter MEM_COLS = 64
) (
    input wire CLK,
    input wire RST_N,
    input wire LINK_CK,
    input wire CKE,
    input wire CS_N,
    input wire RAS_N,
    input wire CAS_N,
    input wire WE_N,
    input wire [11:0] ADDR,
    input wire BANK_SELECT_LOW,
    input wire BANK_SELECT_HIGH,
    input wire [3:0] CAS_LATENCY,
    input wire INTERLEAVED_ORDER,
    input wire [31:0] DQ_IN,
    output reg [31:0] DQ_OUT,
    output reg DQ_OE,
    output reg [3:0] READ_STROBE_OUT,
    output reg READ_STROBE_OE,
    output reg ODT_ENABLE,
    output wire [3:0] BANK_OPEN
);
    localparam RAS_CYC_RAW = (`SDRAR_RAS_MIN_NS + `SDRAR_CLK_PERIOD_NS - 1)
        / `SDRAR_CLK_PERIOD_NS;
    localparam RAS_CYC = (RAS_CYC_RAW < 1) ? 1 : RAS_CYC_RAW;
    localparam PIPE = 16;
    localparam ST_IDLE = 2'h0;
    localparam ST_PRE = 2'h1;
    localparam ST_DATA = 2'h2;
    // ----------------------------------------
    // Pin sampling
    // ----------------------------------------
    wire [19:0] pins_raw = {LINK_CK, CKE, CS_N, RAS_N, CAS_N, WE_N, ADDR,
        BANK_SELECT_HIGH, BANK_SELECT_LOW};
    wire [19:0] pins;
    sdrar_sync #(.W(20)) u_sync (
        .CLK(CLK),
        .RST_N(RST_N),
        .D(pins_raw),
        .Q(pins)
    );
    wire ck = pins[19];
    wire cke = pins[18];
    wire [3:0] cmd = pins[17:14];
    wire [11:0] addr = pins[13:2];
    wire [1:0] bank_sel = pins[1:0];
    // ----------------------------------------
    // Command clock edges
    // ----------------------------------------
    reg ck_q;
    wire ck_rise = ck && !ck_q;
    wire ck_fall = !ck && ck_q;
    wire cmd_valid = ck_rise && cke;
    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    reg is_act;
    reg is_read;
    reg is_pre;
    reg is_write;
    always @* begin
        is_act = 1'b0;
        is_read = 1'b0;
        is_pre = 1'b0;
        is_write = 1'b0;
        if (cmd_valid) begin
            case (cmd)
                `SDRAR_CMD_ACT: begin
                    is_act = 1'b1;
                end
                `SDRAR_CMD_READ: begin
                    is_read = 1'b1;
                end
                `SDRAR_CMD_PRE: begin
                    is_pre = 1'b1;
                end
                `SDRAR_CMD_WRITE: begin
                    is_write = 1'b1;
                end
                default: begin
                    // Deselect and no-operation codes are ignored
                    is_act = 1'b0;
                end
            endcase
        end
    end
    // ----------------------------------------
    // Banks
    // ----------------------------------------
    reg [3:0] burst_done_bank;
    reg [3:0] ap_bank_req;
    genvar b;
    generate
        for (b = 0; b < 4; b = b + 1) begin : g_bank
            sdrar_bank #(.ROW_W(ROW_W), .RAS_CYC(RAS_CYC)) u_bank (
                .CLK(CLK),
                .RST_N(RST_N),
                .act(is_act && bank_sel == b),
                .pre(is_pre && (addr[`SDRAR_AP_BIT] || bank_sel == b)),
                .ap_req(ap_bank_req[b]),
                .burst_done(burst_done_bank[b]),
                .row_in(addr[ROW_W-1:0]),
                .open(BANK_OPEN[b]),
                .row(),
                .ap_pending()
            );
        end
    endgenerate
    // ----------------------------------------
    // Read command capture and latency pipe
    // ----------------------------------------
    // Each slot holds valid, bank, column start; shifted per CK rise
    reg [PIPE-1:0] rd_valid;
    reg [1:0] rd_bank [0:PIPE-1];
    reg [COL_W-1:0] rd_col [0:PIPE-1];
    reg [31:0] mem [0:MEM_COLS-1];
    integer k;
    always @(posedge CLK) begin
        if (!RST_N) begin
            ck_q <= 1'b0;
            rd_valid <= {PIPE{1'b0}};
            ap_bank_req <= 4'h0;
            for (k = 0; k < PIPE; k = k + 1) begin
                rd_bank[k] <= 2'h0;
                rd_col[k] <= {COL_W{1'b0}};
            end
        end else begin
            ck_q <= ck;
            ap_bank_req <= 4'h0;
            if (is_read && addr[`SDRAR_AP_BIT]) begin
                ap_bank_req[bank_sel] <= 1'b1;
            end
            if (ck_rise) begin
                rd_valid <= {rd_valid[PIPE-2:0], is_read};
                rd_bank[0] <= bank_sel;
                rd_col[0] <= addr[COL_W-1:0];
                for (k = 1; k < PIPE; k = k + 1) begin
                    rd_bank[k] <= rd_bank[k-1];
                    rd_col[k] <= rd_col[k-1];
                end
            end
        end
    end
    // ----------------------------------------
    // Array model
    // ----------------------------------------
    // Write commands store DQ_IN at the low six address bits; reset loads each word with its index
    always @(posedge CLK) begin
        if (!RST_N) begin
            for (k = 0; k < MEM_COLS; k = k + 1) begin
                mem[k] <= k;
            end
        end else if (is_write) begin
            mem[addr[5:0]] <= DQ_IN;
        end
    end
    // ----------------------------------------
    // Latency taps
    // ----------------------------------------
    // Slot at CAS latency minus two arrives one CK rise before data; the slot at minus one starts it
    reg [3:0] lat_idx;
    always @* begin
        if (CAS_LATENCY == 4'h0) begin
            // A zero setting is not legal; treat it as the shortest tap
            lat_idx = 4'h0;
        end else begin
            lat_idx = CAS_LATENCY - 4'h1;
        end
    end
    wire start_hit = ck_rise && rd_valid[lat_idx];
    wire pre_hit = ck_rise && (lat_idx != 4'h0) && rd_valid[lat_idx - 4'h1];
    // ----------------------------------------
    // Burst engine
    // ----------------------------------------
    reg [1:0] state;
    reg [1:0] beat;
    reg [COL_W-1:0] col_base;
    reg [1:0] cur_bank;
    reg [3:0] odt_cnt;
    reg [1:0] ord;
    always @* begin
        if (INTERLEAVED_ORDER) begin
            ord = col_base[1:0] ^ beat;
        end else begin
            // Sequential order wraps inside the aligned group of four
            ord = col_base[1:0] + beat;
        end
    end
    wire [5:0] mem_idx = {col_base[5:2], ord};
    wire last_beat = (beat == 2'h3);
    always @(posedge CLK) begin
        if (!RST_N) begin
            state <= ST_IDLE;
            beat <= 2'h0;
            col_base <= {COL_W{1'b0}};
            cur_bank <= 2'h0;
            DQ_OUT <= 32'h0;
            DQ_OE <= 1'b0;
            READ_STROBE_OUT <= 4'h0;
            READ_STROBE_OE <= 1'b0;
            burst_done_bank <= 4'h0;
        end else begin
            burst_done_bank <= 4'h0;
            case (state)
                ST_IDLE: begin
                    if (pre_hit) begin
                        state <= ST_PRE;
                    end
                end
                ST_PRE: begin
                    // Preamble: strobe driven high half a cycle early
                    if (ck_fall) begin
                        READ_STROBE_OE <= 1'b1;
                        READ_STROBE_OUT <= 4'hf;
                    end
                    if (start_hit) begin
                        state <= ST_DATA;
                        beat <= 2'h1;
                        col_base <= rd_col[lat_idx];
                        cur_bank <= rd_bank[lat_idx];
                        DQ_OE <= 1'b1;
                        DQ_OUT <= mem[{rd_col[lat_idx][5:2],
                            rd_col[lat_idx][1:0]}];
                        READ_STROBE_OUT <= 4'h0;
                    end
                end
                ST_DATA: begin
                    // Each CK edge advances one element, strobe toggles
                    if (ck_rise || ck_fall) begin
                        READ_STROBE_OUT <= ~READ_STROBE_OUT;
                        if (beat == 2'h0 && start_hit) begin
                            // Seamless join: next burst starts unbroken
                            col_base <= rd_col[lat_idx];
                            cur_bank <= rd_bank[lat_idx];
                            burst_done_bank[cur_bank] <= 1'b1;
                            DQ_OUT <= mem[{rd_col[lat_idx][5:2],
                                rd_col[lat_idx][1:0]}];
                            beat <= 2'h1;
                        end else if (beat == 2'h0) begin
                            // Postamble half cycle ended, release lines
                            burst_done_bank[cur_bank] <= 1'b1;
                            DQ_OE <= 1'b0;
                            READ_STROBE_OE <= 1'b0;
                            READ_STROBE_OUT <= 4'h0;
                            state <= pre_hit ? ST_PRE : ST_IDLE;
                        end else begin
                            DQ_OUT <= mem[mem_idx];
                            beat <= last_beat ? 2'h0 : beat + 2'h1;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
    // ----------------------------------------
    // Termination control
    // ----------------------------------------
    // Any read in flight, from command until it leaves the 16-slot pipe or its postamble ends, whichever is later
    wire read_busy = is_read || (state != ST_IDLE) || (rd_valid != {PIPE{1'b0}});
    // Held off through an SDRAR_ODT_HOLD countdown after read_busy drops so the bus settles first
    always @(posedge CLK) begin
        if (!RST_N) begin
            ODT_ENABLE <= 1'b1;
            odt_cnt <= 4'h0;
        end else if (read_busy) begin
            ODT_ENABLE <= 1'b0;
            odt_cnt <= `SDRAR_ODT_HOLD;
        end else if (odt_cnt != 4'h0) begin
            odt_cnt <= odt_cnt - 4'h1;
        end else begin
            ODT_ENABLE <= 1'b1;
        end
    end
endmodule // sdrar_core

// [sdrar_core_properties.sv]
// Checker for the read-burst pins of sdrar_core.
// Assumes LINK_CK runs 8 CLK per period and is sampled here directly.
`timescale 1ns/10ps
`include "sdrar_map.vh"
module sdrar_core_properties (
    input wire CLK,
    input wire RST_N,
    input wire LINK_CK,
    input wire CKE,
    input wire CS_N,
    input wire RAS_N,
    input wire CAS_N,
    input wire WE_N,
    input wire BANK_SELECT_LOW,
    input wire BANK_SELECT_HIGH,
    input wire [3:0] CAS_LATENCY,
    input wire [31:0] DQ_OUT,
    input wire DQ_OE,
    input wire [3:0] READ_STROBE_OUT,
    input wire READ_STROBE_OE,
    input wire ODT_ENABLE,
    input wire [3:0] BANK_OPEN
);
    reg ck_q;
    reg armed;
    reg [3:0] rd_cnt;
    reg [1:0] act_bank;
    reg [6:0] run;
    wire ck_rise = LINK_CK && !ck_q;
    wire [3:0] cmd = {CS_N, RAS_N, CAS_N, WE_N};
    wire act_ev = ck_rise && CKE && cmd == `SDRAR_CMD_ACT;
    wire rd_ev = ck_rise && CKE && cmd == `SDRAR_CMD_READ;
    wire cl_due = ck_rise && armed && rd_cnt == CAS_LATENCY - 4'h1;
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    // Only the newest read is timed; older ones are covered by the pace checks
    always @(posedge CLK) begin
        ck_q <= LINK_CK;
        if (!RST_N) begin
            armed <= 1'b0;
            rd_cnt <= 4'h0;
            act_bank <= 2'h0;
            run <= 7'h00;
        end else begin
            if (rd_ev) begin
                armed <= 1'b1;
                rd_cnt <= 4'h0;
            end else if (ck_rise && rd_cnt != 4'hf) begin
                rd_cnt <= rd_cnt + 4'h1;
            end
            if (act_ev) begin
                act_bank <= {BANK_SELECT_HIGH, BANK_SELECT_LOW};
            end
            run <= DQ_OE ? run + 7'h01 : 7'h00;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence preamble_s;
        READ_STROBE_OE && READ_STROBE_OUT == 4'hf && !DQ_OE;
    endsequence
    sequence first_elem_s;
        $rose(DQ_OE) && READ_STROBE_OUT == 4'h0;
    endsequence
    sequence postamble_s;
        !READ_STROBE_OE && $past(READ_STROBE_OUT) == 4'hf;
    endsequence
    sequence pace_s;
        $stable(READ_STROBE_OUT)[*3] ##1 (!DQ_OE || $changed(READ_STROBE_OUT));
    endsequence
    bank_open_a: assert property (act_ev |-> ##[2:8] BANK_OPEN[act_bank])
        else $error("bank not opened by activate");
    read_latency_a: assert property (cl_due |-> ##[2:7] DQ_OE)
        else $error("read data late");
    preamble_a: assert property ($rose(READ_STROBE_OE) |-> preamble_s ##4 first_elem_s)
        else $error("bad read preamble");
    postamble_a: assert property ($fell(DQ_OE) |-> postamble_s)
        else $error("bad read postamble");
    strobe_pace_a: assert property (DQ_OE && $changed(READ_STROBE_OUT) |=> pace_s)
        else $error("strobe not toggling each half period");
    data_strobe_a: assert property (DQ_OE && $past(DQ_OE) && $changed(DQ_OUT) |-> $changed(READ_STROBE_OUT))
        else $error("data changed off a strobe edge");
    lanes_equal_a: assert property (READ_STROBE_OE |-> &READ_STROBE_OUT || ~|READ_STROBE_OUT)
        else $error("strobe lanes differ");
    burst_length_a: assert property ($fell(DQ_OE) |-> run[3:0] == 4'h0 && run != 7'h00)
        else $error("burst not a whole number of four elements");
    odt_off_a: assert property (READ_STROBE_OE || DQ_OE |-> !ODT_ENABLE)
        else $error("termination on while reading");
    data_float_a: assert property (!READ_STROBE_OE |-> !DQ_OE)
        else $error("data driven outside strobe window");
endmodule // sdrar_core_properties
bind sdrar_core sdrar_core_properties sdrar_core_properties_i (.CLK(CLK), .RST_N(RST_N),
    .LINK_CK(LINK_CK), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N),
    .BANK_SELECT_LOW(BANK_SELECT_LOW), .BANK_SELECT_HIGH(BANK_SELECT_HIGH),
    .CAS_LATENCY(CAS_LATENCY), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
    .READ_STROBE_OUT(READ_STROBE_OUT), .READ_STROBE_OE(READ_STROBE_OE),
    .ODT_ENABLE(ODT_ENABLE), .BANK_OPEN(BANK_OPEN));

// [sdrar_ctrl_model.sv]
// Memory controller model: free-running command clock, one command per call.
// Assumes CLK is the block clock; commands change just after a CK fall.
`timescale 1ns/10ps
module sdrar_ctrl_model (
    input wire CLK,
    output reg LINK_CK,
    output reg CKE,
    output reg CS_N,
    output reg RAS_N,
    output reg CAS_N,
    output reg WE_N,
    output reg [11:0] ADDR,
    output reg BANK_SELECT_LOW,
    output reg BANK_SELECT_HIGH
);
    // Odd offset keeps CK edges clear of CLK edges
    initial begin
        LINK_CK = 1'b0;
        #37;
        forever #100 LINK_CK = ~LINK_CK;
    end
    initial begin
        CKE = 1'b1;
        {CS_N, RAS_N, CAS_N, WE_N} = 4'hf;
        ADDR = 12'h000;
        {BANK_SELECT_HIGH, BANK_SELECT_LOW} = 2'h0;
    end
    // ----------------------------------------
    // Command issue
    // ----------------------------------------
    // Commands are at least 2 CK apart; gap adds more. Never writes
    task cmd(input [3:0] c, input [1:0] b, input [11:0] a, input integer gap);
        integer i;
        begin
            @(negedge LINK_CK);
            @(negedge CLK);
            {CS_N, RAS_N, CAS_N, WE_N} = c;
            {BANK_SELECT_HIGH, BANK_SELECT_LOW} = b;
            ADDR = a;
            @(negedge LINK_CK);
            @(negedge CLK);
            // Released lines flip so stale values cannot pass for live ones
            {CS_N, RAS_N, CAS_N, WE_N} = {1'b1, ~c[2:0]};
            {BANK_SELECT_HIGH, BANK_SELECT_LOW} = ~b;
            ADDR = ~a;
            for (i = 2; i < gap; i = i + 1)
                @(negedge LINK_CK);
        end
    endtask
endmodule // sdrar_ctrl_model

// [sdrar_core_tb.sv]
// Self-checking bench for sdrar_core: activates, random reads, precharge.
// Assumes the controller model makes the command clock.
`timescale 1ns/10ps
`include "sdrar_map.vh"
module sdrar_core_tb;
    reg clk;
    reg rst_n;
    reg [3:0] cas_latency;
    reg il;
    reg [31:0] seed;
    reg [3:0] strobe_q;
    integer errors;
    integer checked;
    integer i;
    wire link_ck, cke, cs_n, ras_n, cas_n, we_n, bsl, bsh, dq_oe, strobe_oe, odt;
    wire [11:0] addr;
    wire [31:0] dq_out;
    wire [3:0] strobe;
    wire [3:0] bank_open;
    logic [31:0] got[$];
    logic [31:0] exp_q[$];
    sdrar_ctrl_model sdrar_ctrl_model_i (.CLK(clk), .LINK_CK(link_ck), .CKE(cke),
        .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .ADDR(addr),
        .BANK_SELECT_LOW(bsl), .BANK_SELECT_HIGH(bsh));
    sdrar_core sdrar_core_i (.CLK(clk), .RST_N(rst_n), .LINK_CK(link_ck), .CKE(cke),
        .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .ADDR(addr),
        .BANK_SELECT_LOW(bsl), .BANK_SELECT_HIGH(bsh), .CAS_LATENCY(cas_latency),
        .INTERLEAVED_ORDER(il), .DQ_IN(seed), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
        .READ_STROBE_OUT(strobe), .READ_STROBE_OE(strobe_oe), .ODT_ENABLE(odt),
        .BANK_OPEN(bank_open));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    // Model memory holds its own index; low two bits follow burst order
    function [31:0] exp_word(input [7:0] col, input [1:0] k);
        exp_word = {26'h0, col[5:2], il ? col[1:0] ^ k : col[1:0] + k};
    endfunction
    task check_data(input [31:0] e, input [31:0] g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("unexpected read data: expected %h, seen %h", e, g);
            end
        end
    endtask
    task check_state(input string what, input [7:0] e, input [7:0] g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("unexpected %s: expected %h, seen %h", what, e, g);
            end
        end
    endtask
    task finish_test;
        begin
            if (errors == 0 && checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    // One element per strobe edge while data is driven
    always @(posedge clk) begin
        if (dq_oe === 1'b1 && strobe !== strobe_q)
            got.push_back(dq_out);
        strobe_q <= strobe;
    end
    task rd(input [1:0] b, input [7:0] col, input ap, input integer gap);
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1)
                exp_q.push_back(exp_word(col, k[1:0]));
            sdrar_ctrl_model_i.cmd(`SDRAR_CMD_READ, b, {3'h0, ap, col}, gap);
        end
    endtask
    task drain;
        integer n;
        begin
            n = 0;
            while ((got.size() < exp_q.size() || dq_oe !== 1'b0) && n < 600) begin
                @(negedge clk);
                n = n + 1;
            end
            repeat (8) @(negedge clk);
            check_state("element count", 8'(exp_q.size()), 8'(got.size()));
            while (exp_q.size() > 0 && got.size() > 0)
                check_data(exp_q.pop_front(), got.pop_front());
            exp_q.delete();
            got.delete();
        end
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        errors = 0;
        checked = 0;
        seed = 32'h4a;
        rst_n = 1'b0;
        cas_latency = `SDRAR_CAS_LAT_DEFAULT;
        il = 1'b0;
        strobe_q = 4'h0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        check_state("open banks", 8'h00, {4'h0, bank_open});
        check_state("termination", 8'h01, {7'h00, odt});
        repeat (8) @(negedge clk);
        for (i = 0; i < 4; i = i + 1) begin
            seed = xs(seed);
            sdrar_ctrl_model_i.cmd(`SDRAR_CMD_ACT, i[1:0], seed[11:0], 3);
        end
        check_state("open banks", 8'h0f, {4'h0, bank_open});
        // Seamless or spaced reads; order and latency change only when idle
        for (i = 0; i < 12; i = i + 1) begin
            if (i % 4 == 0) begin
                drain;
                il = i[2] ^ i[3];
                cas_latency = i[3] ? 4'h3 : 4'h5;
            end
            seed = xs(seed);
            rd(seed[1:0], (i % 4 == 1) ? 8'hff : seed[15:8], 1'b0, seed[16] ? 2 : 3);
        end
        drain;
        rd(2'h1, 8'h3c, 1'b1, 3);
        drain;
        check_state("open banks", 8'h0d, {4'h0, bank_open});
        rd(2'h2, 8'h11, 1'b0, 2);
        sdrar_ctrl_model_i.cmd(`SDRAR_CMD_PRE, 2'h0, 12'h100, 2);
        drain;
        check_state("open banks", 8'h00, {4'h0, bank_open});
        sdrar_ctrl_model_i.cmd(`SDRAR_CMD_ACT, 2'h3, 12'h5a5, 3);
        rd(2'h3, 8'h07, 1'b1, 3);
        drain;
        check_state("open banks", 8'h00, {4'h0, bank_open});
        finish_test;
    end
    initial begin
        #500000;
        errors = errors + 1;
        finish_test;
    end
endmodule // sdrar_core_tb
